// file: design/power_pulse_core.sv
// Three-phase power to pulse datapath with Wishbone classic registers.
// Assumes modulator bits and mode pins synchronous to clk_i.
// What this block does
// R1: Two static select pins pick one of four conversion rates.
// R2: Two slow pulse outputs carry average real power for counters or steppers.
// R3: Six modulator streams at 833 kHz decimated to 16-bit samples.
// R4: High-pass filter removes dc from every current channel.
// R5: Per phase, filtered current times voltage gives instantaneous power.
// R6: Each phase product is low-pass filtered into real power.
// R7: Total real power is the sum of three phase values.
// R8: Slow pulses come from long accumulation of total power.
// R9: Calibration pulse uses a shorter interval and faster rate.
// R10: Direct multiply keeps harmonic power for all power factors.
// R11: Sum mode high adds signed energies, low adds absolute values.
// R12: Reverse power flag follows any negative phase, not latched.
// R13: Calibration select pin picks the calibration pulse rate.
// R14: Outside party supplies the master clock.
// R15: Rate select to threshold mapping is a parameter.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module power_pulse_core import meter_pkg::*; #(
	parameter int unsigned ACC_W = 48,
	parameter logic [4*ACC_W-1:0] SLOW_THR = {48'h0000_4000_0000, 48'h0000_8000_0000,
		48'h0001_0000_0000, 48'h0002_0000_0000},
	parameter int unsigned SLOW_PULSE_CYC = 64,
	parameter int unsigned CALIB_PULSE_CYC = 16,
	// Clocks per modulator bit; lowered only to keep simulations short
	parameter int unsigned TICK_DIV = SAMPLE_DIV
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [5:0] mod_bit_i,
	input wire logic rate_select_lo_i,
	input wire logic rate_select_hi_i,
	input wire logic calib_rate_select_i,
	input wire logic sum_mode_select_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic slow_pulse_a_o,
	output logic slow_pulse_b_o,
	output logic calib_pulse_out_o,
	output logic reverse_power_flag_o,
	output logic irq_o
);
	localparam int unsigned PW = 2 * SAMPLE_W + 1;
	localparam int unsigned TW = PW + 3;
	localparam logic [7:0] DIV_LAST = 8'(TICK_DIV - 1);

	typedef enum logic [2:0] {
		PULSE_IDLE = 3'b001,
		PULSE_A = 3'b010,
		PULSE_B = 3'b100
	} slow_state_t;

	function automatic logic [TW-1:0] magnitude(input logic signed [PW:0] v);
		magnitude = v[PW] ? TW'(-v) : TW'(v);
	endfunction

	logic [7:0] div_cnt;
	logic sample_tick;
	logic signed [SAMPLE_W-1:0] sample [6];
	logic [5:0] sample_valid;
	logic signed [SAMPLE_W:0] current_hp [3];
	logic [2:0] hp_valid;
	logic signed [PW-1:0] product [3];
	logic product_valid;
	logic signed [PW:0] phase_power [3];
	logic [2:0] lp_valid;
	logic signed [TW-1:0] total;
	logic total_valid;
	logic [ACC_W-1:0] slow_acc, calib_acc, slow_thr, calib_thr;
	logic slow_fire, calib_fire;
	slow_state_t slow_state;
	logic next_b;
	logic [15:0] slow_cnt, calib_cnt;
	logic [EV_W-1:0] status, mask;
	logic [31:0] pulse_count;
	logic any_neg, neg_seen;
	logic wb_req;

	// R3: modulator bit tick
	always_ff @(posedge clk_i) begin
		if (rst_i)
			div_cnt <= '0;
		else
			div_cnt <= (div_cnt == DIV_LAST) ? 8'h00 : div_cnt + 8'h01;
	end
	assign sample_tick = (div_cnt == DIV_LAST);

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_chan
			// R3: per channel decimator
			sd_decimator #(.D_LOG($clog2(DECIM))) u_dec (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.sample_tick_i(sample_tick),
				.bit_i(mod_bit_i[g]),
				.sample_o(sample[g]),
				.valid_o(sample_valid[g])
			);
		end
		for (g = 0; g < 3; g++) begin : g_phase
			// R4: current dc removal
			first_order_filter #(.W(SAMPLE_W), .K(HPF_SHIFT), .HIGH_PASS(1'b1)) u_hpf (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.valid_i(sample_valid[g]),
				.x_i(sample[g]),
				.y_o(current_hp[g]),
				.valid_o(hp_valid[g])
			);
			// R5: R10: direct product keeps every harmonic
			always_ff @(posedge clk_i) begin
				if (rst_i)
					product[g] <= '0;
				else if (hp_valid[g])
					product[g] <= PW'(current_hp[g] * sample[g+3]);
			end
			// R6: per phase real power
			first_order_filter #(.W(PW), .K(LPF_SHIFT), .HIGH_PASS(1'b0)) u_lpf (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.valid_i(product_valid),
				.x_i(product[g]),
				.y_o(phase_power[g]),
				.valid_o(lp_valid[g])
			);
		end
	endgenerate

	// Voltage samples hold until the next decimated sample, so no realignment
	always_ff @(posedge clk_i) begin
		if (rst_i)
			product_valid <= 1'b0;
		else
			product_valid <= hp_valid[0];
	end

	// R7: R11: phase summation
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			total <= '0;
			total_valid <= 1'b0;
		end else begin
			total_valid <= lp_valid[0];
			if (lp_valid[0]) begin
				if (sum_mode_select_i)
					total <= TW'(phase_power[0]) + TW'(phase_power[1]) + TW'(phase_power[2]);
				else
					total <= magnitude(phase_power[0]) + magnitude(phase_power[1]) + magnitude(phase_power[2]);
			end
		end
	end

	// R12: live flag, no latch
	assign any_neg = phase_power[0][PW] | phase_power[1][PW] | phase_power[2][PW];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reverse_power_flag_o <= 1'b0;
			neg_seen <= 1'b0;
		end else begin
			reverse_power_flag_o <= any_neg;
			neg_seen <= any_neg;
		end
	end

	// R1: R15: threshold lookup
	assign slow_thr = SLOW_THR[{rate_select_hi_i, rate_select_lo_i} * ACC_W +: ACC_W];
	// R9: R13: shorter calibration interval
	assign calib_thr = calib_rate_select_i ? (slow_thr >> CALIB_SHIFT_HI) : (slow_thr >> CALIB_SHIFT_LO);
	assign slow_fire = total_valid && (slow_acc + ACC_W'(total[TW-1] ? -total : total) >= slow_thr);
	assign calib_fire = total_valid && (calib_acc + ACC_W'(total[TW-1] ? -total : total) >= calib_thr);

	// R8: long accumulation of total power
	always_ff @(posedge clk_i) begin
		if (rst_i)
			slow_acc <= '0;
		else if (slow_fire)
			slow_acc <= slow_acc + ACC_W'(total[TW-1] ? -total : total) - slow_thr;
		else if (total_valid)
			slow_acc <= slow_acc + ACC_W'(total[TW-1] ? -total : total);
	end

	// R9: fast calibration accumulation
	always_ff @(posedge clk_i) begin
		if (rst_i)
			calib_acc <= '0;
		else if (calib_fire)
			calib_acc <= calib_acc + ACC_W'(total[TW-1] ? -total : total) - calib_thr;
		else if (total_valid)
			calib_acc <= calib_acc + ACC_W'(total[TW-1] ? -total : total);
	end

	// R2: alternating slow pulses; a fire during a pulse is dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_state <= PULSE_IDLE;
			next_b <= 1'b0;
			slow_cnt <= '0;
			slow_pulse_a_o <= 1'b0;
			slow_pulse_b_o <= 1'b0;
		end else begin
			unique case (slow_state)
				PULSE_IDLE: begin
					if (slow_fire) begin
						slow_state <= next_b ? PULSE_B : PULSE_A;
						slow_pulse_a_o <= !next_b;
						slow_pulse_b_o <= next_b;
						next_b <= !next_b;
						slow_cnt <= 16'(SLOW_PULSE_CYC - 1);
					end
				end
				PULSE_A, PULSE_B: begin
					if (slow_cnt == 16'h0000) begin
						slow_state <= PULSE_IDLE;
						slow_pulse_a_o <= 1'b0;
						slow_pulse_b_o <= 1'b0;
					end else begin
						slow_cnt <= slow_cnt - 16'h0001;
					end
				end
			endcase
		end
	end

	// R9: calibration pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			calib_cnt <= '0;
			calib_pulse_out_o <= 1'b0;
		end else if (calib_fire && !calib_pulse_out_o) begin
			calib_cnt <= 16'(CALIB_PULSE_CYC - 1);
			calib_pulse_out_o <= 1'b1;
		end else if (calib_cnt != 16'h0000) begin
			calib_cnt <= calib_cnt - 16'h0001;
		end else begin
			calib_pulse_out_o <= 1'b0;
		end
	end

	// Wishbone slave, one wait state, ack drops after one cycle
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					STATUS_OFS: wb_dat_o <= 32'(status);
					MASK_OFS: wb_dat_o <= 32'(mask);
					TOTAL_OFS: wb_dat_o <= 32'(total >>> (TW - 32));
					COUNT_OFS: wb_dat_o <= pulse_count;
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Sticky events; a new event beats a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= STATUS_RST;
			mask <= MASK_RST;
			pulse_count <= COUNT_RST;
			irq_o <= 1'b0;
		end else begin
			status <= (status & ~((wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == STATUS_OFS)
				? wb_dat_i[EV_W-1:0] : 3'h0))
				| {any_neg && !neg_seen, calib_fire, slow_fire && slow_state == PULSE_IDLE};
			if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == MASK_OFS)
				mask <= wb_dat_i[EV_W-1:0];
			if (slow_fire && slow_state == PULSE_IDLE)
				pulse_count <= pulse_count + 32'h0000_0001;
			irq_o <= |(status & mask);
		end
	end

	ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_latency_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_req |=> wb_ack_o)
		else $error("ack not after one cycle");
	irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i) irq_o == |($past(status) & $past(mask)))
		else $error("irq does not follow status and mask");
	reverse_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		##1 reverse_power_flag_o == ($past(phase_power[0][PW]) || $past(phase_power[1][PW]) || $past(phase_power[2][PW])))
		else $error("reverse flag wrong");
	abs_sum_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		lp_valid[0] && !sum_mode_select_i |=> !total[TW-1])
		else $error("absolute sum went negative");
	slow_width_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
		$rose(slow_pulse_a_o | slow_pulse_b_o) |-> (slow_pulse_a_o | slow_pulse_b_o) [*8])
		else $error("slow pulse too short");
	slow_exclusive_a: assert property (@(posedge clk_i) disable iff (rst_i) !(slow_pulse_a_o && slow_pulse_b_o)) // R2
		else $error("both slow pulses high");
	slow_cause_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		$rose(slow_pulse_a_o | slow_pulse_b_o) |-> $past(slow_fire))
		else $error("slow pulse without accumulator crossing");
	calib_faster_a: assert property (@(posedge clk_i) disable iff (rst_i) calib_thr < slow_thr || slow_thr == '0) // R9
		else $error("calibration interval not shorter");
	tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i) sample_tick |=> !sample_tick [*8]) // R3
		else $error("modulator tick too fast");
	chan_aligned_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		(sample_valid == '0 || sample_valid == '1) && (lp_valid == '0 || lp_valid == '1))
		else $error("channel samples out of step");
	slow_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(slow_pulse_b_o));
	calib_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(calib_pulse_out_o));
	reverse_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(reverse_power_flag_o));
	irq_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule

// file: design/meter_pkg.sv
// Shared constants for the three-phase power-to-pulse datapath.
// Assumes a 125 MHz system clock and Wishbone classic register access.
package meter_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned SAMPLE_HZ = 833_000;
	// Clocks per modulator bit, rounded down so the tick never runs slow
	localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
	localparam int unsigned DECIM = 256;
	localparam int unsigned SAMPLE_W = 16;
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] MASK_OFS = 8'h04;
	localparam logic [7:0] TOTAL_OFS = 8'h08;
	localparam logic [7:0] COUNT_OFS = 8'h0C;
	localparam int unsigned EV_SLOW = 0;
	localparam int unsigned EV_CALIB = 1;
	localparam int unsigned EV_REVERSE = 2;
	localparam int unsigned EV_W = 3;
	localparam logic [EV_W-1:0] STATUS_RST = 3'h0;
	localparam logic [EV_W-1:0] MASK_RST = 3'h0;
	localparam logic [31:0] COUNT_RST = 32'h0000_0000;
	localparam int unsigned HPF_SHIFT = 10;
	localparam int unsigned LPF_SHIFT = 8;
	localparam int unsigned CALIB_SHIFT_LO = 4;
	localparam int unsigned CALIB_SHIFT_HI = 6;
endpackage

// file: design/sd_decimator.sv
// Second-order comb-integrator decimator for one modulator bit stream.
// Assumes sample_tick_i pulses once per modulator bit.
`timescale 1ns/100ps
module sd_decimator import meter_pkg::*; #(
	parameter int unsigned D_LOG = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sample_tick_i,
	input wire logic bit_i,
	output logic signed [SAMPLE_W-1:0] sample_o,
	output logic valid_o
);
	localparam int unsigned IW = 2 * D_LOG + 1;
	localparam logic [IW-1:0] MID = IW'(1) << (IW - 2);
	logic [IW-1:0] int1, int2, last2, last1;
	logic [D_LOG-1:0] phase;
	logic [IW-1:0] next_diff1, next_diff2;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int1 <= '0;
			int2 <= '0;
			phase <= '0;
		end else if (sample_tick_i) begin
			int1 <= int1 + IW'(bit_i);
			int2 <= int2 + int1;
			phase <= phase + 1'b1;
		end
	end

	always_comb begin
		next_diff1 = int2 - last2;
		next_diff2 = next_diff1 - last1;
	end

	// Comb stage runs once per decimated sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last2 <= '0;
			last1 <= '0;
			sample_o <= '0;
			valid_o <= 1'b0;
		end else begin
			valid_o <= sample_tick_i && (phase == '1);
			if (sample_tick_i && (phase == '1)) begin
				last2 <= int2;
				last1 <= next_diff1;
				// Full-scale ones would wrap, so clip to the top code
				if (next_diff2 >= (MID << 1))
					sample_o <= {1'b0, {(SAMPLE_W-1){1'b1}}};
				else
					sample_o <= SAMPLE_W'(next_diff2 - MID);
			end
		end
	end
endmodule

// file: design/first_order_filter.sv
// Single-pole IIR section; low-pass output, or input minus low-pass.
// Assumes valid_i marks each new input sample.
`timescale 1ns/100ps
module first_order_filter #(
	parameter int unsigned W = 16,
	parameter int unsigned K = 8,
	parameter bit HIGH_PASS = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic valid_i,
	input wire logic signed [W-1:0] x_i,
	output logic signed [W:0] y_o,
	output logic valid_o
);
	logic signed [W+K:0] state;
	logic signed [W:0] smooth;
	assign smooth = (W+1)'(state >>> K);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '0;
			y_o <= '0;
			valid_o <= 1'b0;
		end else begin
			valid_o <= valid_i;
			if (valid_i) begin
				state <= state + (W+K+1)'(x_i) - (W+K+1)'(smooth);
				y_o <= HIGH_PASS ? ((W+1)'(x_i) - smooth) : smooth;
			end
		end
	end
endmodule

// file: verification/pulse_sink_model.sv
// Pulse consumer standing in for a step counter or stepper drive.
// Assumes pulse outputs are registered to clk_i.
`timescale 1ns/100ps
module pulse_sink_model #(
	parameter int SLOW_W = 64,
	parameter int CALIB_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_a_i,
	input wire logic slow_b_i,
	input wire logic calib_i,
	output int slow_cnt_o,
	output int calib_cnt_o,
	output int bad_cnt_o
);
	int run_a, run_b, run_c;
	logic want_b;
	always @(posedge clk_i) begin
		if (rst_i) begin
			{run_a, run_b, run_c, slow_cnt_o, calib_cnt_o, bad_cnt_o} <= '0;
			want_b <= 1'b0;
		end else begin
			run_a <= slow_a_i ? run_a + 1 : 0;
			run_b <= slow_b_i ? run_b + 1 : 0;
			run_c <= calib_i ? run_c + 1 : 0;
			// Only finished pulses count, a cut one at the end is ignored
			if (!slow_a_i && run_a != 0) begin
				slow_cnt_o <= slow_cnt_o + 1;
				want_b <= 1'b1;
				if (run_a != SLOW_W || want_b) bad_cnt_o <= bad_cnt_o + 1;
			end
			if (!slow_b_i && run_b != 0) begin
				slow_cnt_o <= slow_cnt_o + 1;
				want_b <= 1'b0;
				if (run_b != SLOW_W || !want_b) bad_cnt_o <= bad_cnt_o + 1;
			end
			if (!calib_i && run_c != 0) begin
				calib_cnt_o <= calib_cnt_o + 1;
				if (run_c != CALIB_W) bad_cnt_o <= bad_cnt_o + 1;
			end
		end
	end
endmodule

// file: verification/tb_power_pulse_core.sv
// Self-checking bench for the power to pulse datapath.
// Assumes meter_pkg and a pulse sink model; all phases fed reverse power.
`timescale 1ns/100ps
module tb_power_pulse_core;
	import meter_pkg::*;
	// Thresholds sized so slow pulses start within seven samples, yet fewer than calibration ones
	localparam logic [191:0] THR = {48'h0000_0400_0000, 48'h0000_0500_0000, 48'h0000_0600_0000,
		48'h0000_0800_0000};
	// Fast modulator tick keeps the run short; one sample per TICK * DECIM clocks
	localparam int unsigned TICK = 10;
	logic clk_i = 1'b0, rst_i = 1'b1;
	// Currents all ones, voltages all zeros: every phase negative
	logic [5:0] mod_bit_i = 6'h07;
	logic rate_select_lo_i = 1'b0, rate_select_hi_i = 1'b0, calib_rate_select_i = 1'b0;
	logic sum_mode_select_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, r;
	logic wb_ack_o, slow_pulse_a_o, slow_pulse_b_o, calib_pulse_out_o, reverse_power_flag_o, irq_o;
	logic [2:0] m;
	logic [7:0] adrs [6] = '{STATUS_OFS, MASK_OFS, TOTAL_OFS, COUNT_OFS, 8'h10, 8'hFC};
	int err_total, checks_done, slow_cnt, calib_cnt, bad_cnt, n;

	power_pulse_core #(.SLOW_THR(THR), .TICK_DIV(TICK)) i_power_pulse_core (.clk_i(clk_i), .rst_i(rst_i),
		.mod_bit_i(mod_bit_i),
		.rate_select_lo_i(rate_select_lo_i), .rate_select_hi_i(rate_select_hi_i),
		.calib_rate_select_i(calib_rate_select_i), .sum_mode_select_i(sum_mode_select_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slow_pulse_a_o(slow_pulse_a_o),
		.slow_pulse_b_o(slow_pulse_b_o), .calib_pulse_out_o(calib_pulse_out_o),
		.reverse_power_flag_o(reverse_power_flag_o), .irq_o(irq_o));
	pulse_sink_model i_pulse_sink_model (.clk_i(clk_i), .rst_i(rst_i), .slow_a_i(slow_pulse_a_o),
		.slow_b_i(slow_pulse_b_o), .calib_i(calib_pulse_out_o), .slow_cnt_o(slow_cnt), .calib_cnt_o(calib_cnt),
		.bad_cnt_o(bad_cnt));

	always #4 clk_i = ~clk_i;

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		check("wb_ack", {31'h0, wb_ack_o}, 32'h1);
	endtask

	task results();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Masked writes need byte lane 0
	function logic [2:0] exp_mask(input logic [31:0] d, input logic [3:0] s, input logic [2:0] old);
		return s[0] ? d[2:0] : old;
	endfunction

	// Signed sum of reverse phases is negative, magnitude sum positive
	function logic exp_sign(input logic signed_sum);
		return signed_sum;
	endfunction

	initial begin
		repeat (32 * TICK * DECIM) @(posedge clk_i);
		check("watchdog", 32'h1, 32'h0);
		results();
	end

	initial begin
		void'($urandom(32'hEB264A33));
		r = $urandom;
		{rate_select_hi_i, rate_select_lo_i, calib_rate_select_i} <= r[2:0];
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (adrs[i]) begin
			wb(1'b0, adrs[i], 32'h0, 4'hF);
			check("reset_read", q, adrs[i] == COUNT_OFS ? COUNT_RST : 32'h0);
		end
		check("irq_reset", {31'h0, irq_o}, 32'h0);
		$display("done: reset values");
		m = MASK_RST;
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			wb(1'b1, MASK_OFS, r, i == 1 ? 4'hE : 4'hF);
			m = exp_mask(r, i == 1 ? 4'hE : 4'hF, m);
			wb(1'b0, MASK_OFS, 32'h0, 4'hF);
			check("mask_rw", {29'h0, q[2:0]}, {29'h0, m});
			wb(1'b1, 8'h10, r, 4'hF);
			wb(1'b0, 8'h10, 32'h0, 4'hF);
			check("unmapped", q, 32'h0);
		end
		wb(1'b1, MASK_OFS, 32'h0, 4'hF);
		$display("done: mask and unmapped");
		n = 0;
		while (reverse_power_flag_o !== 1'b1 && n < 50000) begin
			@(posedge clk_i);
			n++;
		end
		check("reverse_flag", {31'h0, reverse_power_flag_o}, 32'h1);
		wb(1'b0, STATUS_OFS, 32'h0, 4'hF);
		check("status_rev", {31'h0, q[EV_REVERSE]}, 32'h1);
		check("irq_masked", {31'h0, irq_o}, 32'h0);
		wb(1'b1, MASK_OFS, 32'h4, 4'hF);
		repeat (2) @(posedge clk_i);
		check("irq_on", {31'h0, irq_o}, 32'h1);
		wb(1'b1, STATUS_OFS, 32'h4, 4'hF);
		wb(1'b0, STATUS_OFS, 32'h0, 4'hF);
		check("status_clr", {31'h0, q[EV_REVERSE]}, 32'h0);
		repeat (2) @(posedge clk_i);
		check("irq_off", {31'h0, irq_o}, 32'h0);
		wb(1'b0, TOTAL_OFS, 32'h0, 4'hF);
		check("total_signed", {31'h0, q[31]}, {31'h0, exp_sign(1'b1)});
		check("total_nonzero", {31'h0, q != 32'h0}, 32'h1);
		$display("done: reverse power and interrupt");
		sum_mode_select_i <= 1'b0;
		repeat (TICK * DECIM + 400) @(posedge clk_i);
		wb(1'b0, TOTAL_OFS, 32'h0, 4'hF);
		check("total_abs", {31'h0, q[31]}, {31'h0, exp_sign(1'b0)});
		check("total_abs_nz", {31'h0, q != 32'h0}, 32'h1);
		check("flag_held", {31'h0, reverse_power_flag_o}, 32'h1);
		$display("done: sum mode");
		// Let the accumulators run for a dozen more samples
		repeat (12 * TICK * DECIM) @(posedge clk_i);
		wb(1'b0, COUNT_OFS, 32'h0, 4'hF);
		check("pulse_count", {31'h0, q >= slow_cnt && q <= slow_cnt + 1}, 32'h1);
		check("slow_seen", {31'h0, slow_cnt > 0}, 32'h1);
		check("calib_faster", {31'h0, calib_cnt > slow_cnt}, 32'h1);
		check("pulse_shape", bad_cnt, 32'h0);
		wb(1'b0, STATUS_OFS, 32'h0, 4'hF);
		check("status_pulses", {30'h0, q[EV_CALIB], q[EV_SLOW]}, 32'h3);
		$display("done: pulse outputs");
		results();
	end
endmodule
